// ### rtl/ctp_packer.sv
// CAN transmit signal packer: registers, scheduler, scaling and frame assembly
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Behaviour
// - Size code 0 disables a signal, 1..6 give 1, 2, 4 bits and 1, 2, 4 bytes.
// - Each signal's low part sits at a byte position 0..7; signal three defaults to byte 4.
// - Signal four defaults to byte 6 with the two-byte size, filling the last two bytes.
// - The bit position inside the byte applies only to sub-byte sizes.
// - Channels sharing a group number are scheduled by the lowest enabled channel's interval only.
// - A zero interval on that lowest channel suppresses the group entirely.
// - Signal four defaults to the AC input source and the continuous type.
module ctp_packer import ctp_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	input wire logic REF_CLK_I,
	input wire logic SRST_I,
	input wire logic CE_I,
	input wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic [NAC*32-1:0] AC_VALUE_I,
	output logic FRAME_VALID_O,
	input wire logic FRAME_READY_I,
	output logic [15:0] FRAME_PGN_O,
	output logic [63:0] FRAME_DATA_O
);
	localparam int MS_W = $clog2(MS_CYCLES + 1);

	// ==========================================================
	// Register storage
	logic [NCH-1:0] ch_en;
	logic [15:0] ch_pgn [NCH];
	logic [15:0] ch_rate [NCH];
	logic [31:0] sig_cfg [NSIG];
	logic [31:0] sig_res [NSIG];
	logic [31:0] sig_off [NSIG];
	logic [15:0] frame_cnt;
	logic [NCH-1:0] pend;
	ctp_state_t st;

	// Address decode: {kind, index}
	function automatic logic [4:0] decode(input logic [7:0] a);
		logic [7:0] d;
		d = a - A_SIG_BASE;
		if (a[1:0] != 2'h0) return {K_NONE, 2'h0};
		else if (a == A_CTRL) return {K_CTRL, 2'h0};
		else if (a == A_STATUS) return {K_STAT, 2'h0};
		else if (a >= A_CH_BASE && a < A_SIG_BASE) return {K_CH, a[3:2]};
		else if (a >= A_SIG_BASE && a < A_SIG_END && a[3:2] != 2'h3) return {K_CFG + {1'b0, a[3:2]}, d[5:4]};
		else return {K_NONE, 2'h0};
	endfunction : decode

	// Current contents of a decoded register
	function automatic logic [31:0] reg_word(input logic [4:0] k);
		logic [1:0] i;
		i = k[1:0];
		unique case (k[4:2])
			K_CTRL: return {{(32-NCH){1'b0}}, ch_en};
			K_STAT: return {11'h0, st != ST_IDLE, pend, frame_cnt};
			K_CH: return {ch_rate[i], ch_pgn[i]};
			K_CFG: return sig_cfg[i];
			K_RES: return sig_res[i];
			K_OFF: return sig_off[i];
			default: return 32'h0;
		endcase
	endfunction : reg_word

	// ==========================================================
	// AXI4-Lite write channel: address and data taken in either order
	logic aw_got;
	logic w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_do;
	logic [4:0] wr_dec;
	logic [31:0] wr_word;

	assign S_AXI_AWREADY_O = !aw_got;
	assign S_AXI_WREADY_O = !w_got;
	assign wr_do = aw_got && w_got && !S_AXI_BVALID_O;
	assign wr_dec = decode(aw_addr);

	// Byte strobes merge new bytes into the old word
	always_comb begin
		wr_word = reg_word(wr_dec);
		for (int b = 0; b < 4; b++) begin
			if (w_strb[b]) wr_word[b*8 +: 8] = w_data[b*8 +: 8];
		end
	end

	// Write handshake and response
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= RESP_OKAY;
		end else if (CE_I) begin
			if (S_AXI_AWVALID_I && !aw_got) begin
				aw_got <= 1'b1;
				aw_addr <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && !w_got) begin
				w_got <= 1'b1;
				w_data <= S_AXI_WDATA_I;
				w_strb <= S_AXI_WSTRB_I;
			end
			if (wr_do) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= (wr_dec[4:2] == K_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel, data registered at the handshake
	assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= 32'h0;
			S_AXI_RRESP_O <= RESP_OKAY;
		end else if (CE_I) begin
			if (S_AXI_ARVALID_I && !S_AXI_RVALID_O) begin
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RDATA_O <= reg_word(decode(S_AXI_ARADDR_I));
				S_AXI_RRESP_O <= (decode(S_AXI_ARADDR_I) == {K_NONE, 2'h0}) ? RESP_SLVERR : RESP_OKAY;
			end else if (S_AXI_RREADY_I) begin
				S_AXI_RVALID_O <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Configuration registers; reset acts even while the clock enable is low
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			ch_en <= '0;
			for (int i = 0; i < NCH; i++) begin
				ch_pgn[i] <= DEF_PGN_BASE + 16'(i);
				ch_rate[i] <= DEF_RATE;
			end
			for (int s = 0; s < NSIG; s++) begin
				sig_cfg[s] <= ctp_def_cfg(s);
				sig_res[s] <= DEF_RES;
				sig_off[s] <= DEF_OFF;
			end
		end else if (CE_I && wr_do) begin
			unique case (wr_dec[4:2])
				K_CTRL: ch_en <= wr_word[NCH-1:0];
				K_CH: begin
					ch_pgn[wr_dec[1:0]] <= wr_word[15:0];
					ch_rate[wr_dec[1:0]] <= wr_word[31:16];
				end
				K_CFG: sig_cfg[wr_dec[1:0]] <= wr_word & CFG_MASK;
				K_RES: sig_res[wr_dec[1:0]] <= wr_word;
				K_OFF: sig_off[wr_dec[1:0]] <= wr_word;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Millisecond tick shared by all repetition timers
	logic [MS_W-1:0] ms_cnt;
	logic ms_tick;
	assign ms_tick = (ms_cnt == MS_W'(MS_CYCLES - 1));
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) ms_cnt <= '0;
		else if (CE_I) ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
	end

	// Per channel: ownership of its group number, timer and pending request
	logic [NCH-1:0] take;
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic own;
		logic act;
		logic fire;
		logic p;
		logic [15:0] tmr;

		// Only the lowest enabled channel with this group number schedules it
		always_comb begin
			own = ch_en[c];
			for (int j = 0; j < c; j++) begin
				if (ch_en[j] && ch_pgn[j] == ch_pgn[c]) own = 1'b0;
			end
		end
		assign act = own && (ch_rate[c] != 16'h0);
		assign fire = act && ms_tick && (tmr >= ch_rate[c] - 16'h1);
		assign pend[c] = p;

		always_ff @(posedge REF_CLK_I) begin
			if (SRST_I) tmr <= 16'h0;
			else if (CE_I) begin
				if (!act) tmr <= 16'h0;
				else if (ms_tick) tmr <= fire ? 16'h0 : tmr + 16'h1;
			end
		end

		// A new expiry wins over the clear by the frame builder
		always_ff @(posedge REF_CLK_I) begin
			if (SRST_I) p <= 1'b0;
			else if (CE_I) p <= act && (fire || (p && !take[c]));
		end

		property p_not_owner;
			@(posedge REF_CLK_I) disable iff (SRST_I) CE_I && !own |=> !p;
		endproperty
		a_not_owner: assert property (p_not_owner) else $error("shadowed channel requested a frame");
		property p_zero_rate;
			@(posedge REF_CLK_I) disable iff (SRST_I) CE_I && own && ch_rate[c] == 16'h0 |=> !p;
		endproperty
		a_zero_rate: assert property (p_zero_rate) else $error("zero interval group requested a frame");
	end

	// Lowest pending channel is served first
	logic [1:0] sel;
	always_comb begin
		sel = 2'h0;
		for (int c = NCH - 1; c >= 0; c--) begin
			if (pend[c]) sel = 2'(c);
		end
	end
	assign take = (st == ST_IDLE && |pend) ? (NCH'(1) << sel) : '0;

	// ==========================================================
	// Signal scaling and packing
	logic [1:0] sig;
	logic [63:0] payload;
	logic [15:0] cur_pgn;
	logic neg;
	logic [2:0] cur_size;
	logic [2:0] cur_byte;
	logic [2:0] cur_bit;
	logic [2:0] cur_num;
	logic sig_on;
	logic [31:0] src_val;
	logic [31:0] diff;
	logic [31:0] quo;
	logic div_done;
	logic [31:0] raw;
	logic [6:0] pack_sh;
	logic [63:0] mask;
	logic buf_ready;

	assign cur_size = sig_cfg[sig][F_SIZE +: 3];
	assign cur_byte = sig_cfg[sig][F_BYTE +: 3];
	assign cur_bit = sig_cfg[sig][F_BIT +: 3];
	assign cur_num = sig_cfg[sig][F_NUM +: 3];
	assign sig_on = cur_size != SZ_OFF && cur_size <= SZ_4BYTE && sig_cfg[sig][F_TYPE +: 2] != TYPE_OFF;
	assign diff = src_val - sig_off[sig];
	assign raw = neg ? -quo : quo;

	// Source selection: AC input number 1..NAC, anything else reads zero
	always_comb begin
		src_val = 32'h0;
		if (sig_cfg[sig][F_SRC +: 2] == SRC_AC && cur_num != 3'h0 && cur_num <= 3'(NAC)) begin
			src_val = AC_VALUE_I[32*(int'(cur_num)-1) +: 32];
		end
	end

	// Field width from the size code and its shift into the payload
	always_comb begin
		unique case (cur_size)
			SZ_1BIT: mask = 64'h1;
			SZ_2BIT: mask = 64'h3;
			SZ_4BIT: mask = 64'hf;
			SZ_BYTE: mask = 64'hff;
			SZ_2BYTE: mask = 64'hffff;
			SZ_4BYTE: mask = 64'hffff_ffff;
			default: mask = 64'h0;
		endcase
		pack_sh = {1'b0, cur_byte, 3'h0} + ((cur_size < SZ_BYTE) ? {4'h0, cur_bit} : 7'h0);
	end

	// Magnitude divided, sign restored afterwards
	ctp_divider #(.W(32)) u_div (
		.clk_i(REF_CLK_I),
		.srst_i(SRST_I),
		.ce_i(CE_I),
		.start_i(st == ST_LOAD && sig_on),
		.num_i(diff[31] ? -diff : diff),
		.den_i(sig_res[sig]),
		.done_o(div_done),
		.quo_o(quo)
	);

	// Frame builder; fields past byte 7 are cut off at the payload edge
	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			st <= ST_IDLE;
			sig <= 2'h0;
			payload <= 64'h0;
			cur_pgn <= 16'h0;
			neg <= 1'b0;
			frame_cnt <= 16'h0;
		end else if (CE_I) begin
			unique case (st)
				ST_IDLE: if (|pend) begin
					cur_pgn <= ch_pgn[sel];
					payload <= 64'h0;
					sig <= 2'h0;
					st <= ST_LOAD;
				end
				ST_LOAD: begin
					neg <= diff[31];
					if (sig_on) st <= ST_DIV;
					else if (sig == 2'(NSIG - 1)) st <= ST_PUSH;
					else sig <= sig + 2'h1;
				end
				ST_DIV: if (div_done) st <= ST_PACK;
				ST_PACK: begin
					payload <= (payload & ~(mask << pack_sh)) | (({32'h0, raw} & mask) << pack_sh);
					if (sig == 2'(NSIG - 1)) st <= ST_PUSH;
					else begin
						sig <= sig + 2'h1;
						st <= ST_LOAD;
					end
				end
				ST_PUSH: if (buf_ready) begin
					st <= ST_IDLE;
					frame_cnt <= frame_cnt + 16'h1;
				end
			endcase
		end
	end

	// Finished frames wait here so a stalled receiver loses none
	ctp_buf2 #(.W(80)) u_buf (
		.clk_i(REF_CLK_I),
		.srst_i(SRST_I),
		.ce_i(CE_I),
		.in_valid_i(st == ST_PUSH),
		.in_ready_o(buf_ready),
		.in_data_i({cur_pgn, payload}),
		.out_valid_o(FRAME_VALID_O),
		.out_ready_i(FRAME_READY_I),
		.out_data_o({FRAME_PGN_O, FRAME_DATA_O})
	);

	// ==========================================================
	// Checks
	property p_size_off;
		@(posedge REF_CLK_I) disable iff (SRST_I) CE_I && st == ST_LOAD && cur_size == SZ_OFF |=> st != ST_DIV;
	endproperty
	a_size_off: assert property (p_size_off) else $error("disabled signal was converted");
	property p_one_bit;
		@(posedge REF_CLK_I) disable iff (SRST_I) CE_I && st == ST_PACK && cur_size == SZ_1BIT
		|=> ((payload ^ $past(payload)) & ~(64'h1 << $past(pack_sh))) == 64'h0;
	endproperty
	a_one_bit: assert property (p_one_bit) else $error("one-bit field touched other bits");
	property p_def_sig3;
		@(posedge REF_CLK_I) disable iff (SRST_I) $fell(SRST_I) |-> sig_cfg[2][F_BYTE +: 3] == DEF_BYTE[6 +: 3];
	endproperty
	a_def_sig3: assert property (p_def_sig3) else $error("signal three byte default wrong");
	property p_def_sig4;
		@(posedge REF_CLK_I) disable iff (SRST_I) $fell(SRST_I)
		|-> sig_cfg[3][F_BYTE +: 3] == DEF_BYTE[9 +: 3] && sig_cfg[3][F_SIZE +: 3] == SZ_2BYTE;
	endproperty
	a_def_sig4: assert property (p_def_sig4) else $error("signal four placement default wrong");
	property p_bit_ignored;
		@(posedge REF_CLK_I) disable iff (SRST_I) st == ST_PACK && cur_size >= SZ_BYTE |-> pack_sh == {1'b0, cur_byte, 3'h0};
	endproperty
	a_bit_ignored: assert property (p_bit_ignored) else $error("bit position used for byte field");
	property p_def_src4;
		@(posedge REF_CLK_I) disable iff (SRST_I) $fell(SRST_I)
		|-> sig_cfg[3][F_TYPE +: 2] == TYPE_CONT && sig_cfg[3][F_SRC +: 2] == SRC_AC;
	endproperty
	a_def_src4: assert property (p_def_src4) else $error("signal four source default wrong");
	property p_pack_lsb;
		@(posedge REF_CLK_I) disable iff (SRST_I) CE_I && st == ST_PACK && cur_size == SZ_2BYTE && cur_byte <= 3'h6
		|=> ((payload >> $past(pack_sh)) & 64'hffff) == {48'h0, $past(raw[15:0])};
	endproperty
	a_pack_lsb: assert property (p_pack_lsb) else $error("two-byte field not packed low byte first");
endmodule : ctp_packer
`default_nettype wire

// ### rtl/ctp_pkg.sv
// Shared constants, register map and types of the CAN transmit signal packer
package ctp_pkg;
	// ==========================================================
	// Sizes
	localparam int NSIG = 4;
	localparam int NCH = 4;
	localparam int NAC = 4;
	localparam int AXI_AW = 8;
	// ==========================================================
	// Signal size codes
	localparam logic [2:0] SZ_OFF = 3'h0;
	localparam logic [2:0] SZ_1BIT = 3'h1;
	localparam logic [2:0] SZ_2BIT = 3'h2;
	localparam logic [2:0] SZ_4BIT = 3'h3;
	localparam logic [2:0] SZ_BYTE = 3'h4;
	localparam logic [2:0] SZ_2BYTE = 3'h5;
	localparam logic [2:0] SZ_4BYTE = 3'h6;
	// Data types and sources
	localparam logic [1:0] TYPE_OFF = 2'h0;
	localparam logic [1:0] TYPE_CONT = 2'h2;
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_AC = 2'h1;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_CH_BASE = 8'h10;
	localparam logic [7:0] A_SIG_BASE = 8'h20;
	localparam logic [7:0] A_SIG_END = 8'h60;
	// Decoded register kinds
	localparam logic [2:0] K_NONE = 3'h0;
	localparam logic [2:0] K_CTRL = 3'h1;
	localparam logic [2:0] K_STAT = 3'h2;
	localparam logic [2:0] K_CH = 3'h3;
	localparam logic [2:0] K_CFG = 3'h4;
	localparam logic [2:0] K_RES = 3'h5;
	localparam logic [2:0] K_OFF = 3'h6;
	// Signal configuration field positions
	localparam int F_SIZE = 0;
	localparam int F_BYTE = 4;
	localparam int F_BIT = 8;
	localparam int F_TYPE = 12;
	localparam int F_SRC = 16;
	localparam int F_NUM = 20;
	localparam logic [31:0] CFG_MASK = 32'h0073_3777;
	// ==========================================================
	// Reset values
	localparam logic [11:0] DEF_BYTE = {3'h6, 3'h4, 3'h2, 3'h0};
	localparam logic [31:0] DEF_RES = 32'h0000_0001;
	localparam logic [31:0] DEF_OFF = 32'h0000_0000;
	localparam logic [15:0] DEF_RATE = 16'h03e8;
	localparam logic [15:0] DEF_PGN_BASE = 16'hff00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing: one millisecond of repetition interval
	localparam int T_MS_NS = 1000000;
	localparam int CLK_NS = 5;
	localparam int MS_CYCLES_DEF = T_MS_NS / CLK_NS;

	typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_DIV, ST_PACK, ST_PUSH} ctp_state_t;

	// Reset contents of one signal configuration word
	function automatic logic [31:0] ctp_def_cfg(input int s);
		logic [2:0] num;
		num = 3'(s + 1);
		return (32'(SZ_2BYTE) << F_SIZE) | (32'(DEF_BYTE[s*3 +: 3]) << F_BYTE)
			| (32'(TYPE_CONT) << F_TYPE) | (32'(SRC_AC) << F_SRC) | (32'(num) << F_NUM);
	endfunction : ctp_def_cfg
endpackage : ctp_pkg

// ### rtl/ctp_buf2.sv
// Two-entry frame buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ctp_buf2 #(
	parameter int W = 80
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	logic [W-1:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] cnt;
	logic push;
	logic pop;

	// Full and empty come straight from the count, so a stalled reader fills it
	assign in_ready_o = (cnt != 2'h2);
	assign out_valid_o = (cnt != 2'h0);
	assign out_data_o = mem[rd_ptr];
	assign push = ce_i && in_valid_i && in_ready_o;
	assign pop = ce_i && out_valid_o && out_ready_i;

	// Pointers and fill level
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (push) wr_ptr <= ~wr_ptr;
			if (pop) rd_ptr <= ~rd_ptr;
			cnt <= cnt + {1'b0, push} - {1'b0, pop};
		end
	end

	// Storage, no reset needed since valid gates it
	always_ff @(posedge clk_i) begin
		if (push) mem[wr_ptr] <= in_data_i;
	end

	// A refused frame must be offered again, unchanged, on the next cycle
	sequence s_stalled;
		out_valid_o && !out_ready_i && ce_i;
	endsequence
	sequence s_still_offered;
		out_valid_o && $stable(out_data_o);
	endsequence
	property p_hold_out;
		@(posedge clk_i) disable iff (srst_i)
		s_stalled |=> s_still_offered;
	endproperty
	a_hold_out: assert property (p_hold_out) else $error("buffered frame changed while stalled");
endmodule : ctp_buf2
`default_nettype wire

// ### rtl/ctp_divider.sv
// Sequential unsigned divider used to scale source values
`timescale 1ns/1ps
`default_nettype none
module ctp_divider #(
	parameter int W = 32
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic [W-1:0] num_i,
	input wire logic [W-1:0] den_i,
	output logic done_o,
	output logic [W-1:0] quo_o
);
	logic [W-1:0] num;
	logic [W-1:0] den;
	logic [W:0] rem;
	logic [W:0] trial;
	logic [$clog2(W+1)-1:0] cnt;

	// One quotient bit per cycle; a zero divisor saturates to all ones
	assign trial = {rem[W-1:0], quo_o[W-1]} - {1'b0, den};

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt <= '0;
			done_o <= 1'b0;
			rem <= '0;
			quo_o <= '0;
			num <= '0;
			den <= '0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (start_i) begin
				num <= num_i;
				den <= den_i;
				quo_o <= num_i;
				rem <= '0;
				cnt <= ($clog2(W+1))'(W);
			end else if (cnt != '0) begin
				cnt <= cnt - 1'b1;
				done_o <= (cnt == 1);
				if (!trial[W]) begin
					rem <= trial;
					quo_o <= {quo_o[W-2:0], 1'b1};
				end else begin
					rem <= {rem[W-1:0], quo_o[W-1]};
					quo_o <= {quo_o[W-2:0], 1'b0};
				end
			end
		end
	end

	property p_quotient;
		@(posedge clk_i) disable iff (srst_i)
		done_o && den != '0 |-> (64'(quo_o) * 64'(den) + 64'(rem[W-1:0])) == 64'(num);
	endproperty
	a_quotient: assert property (p_quotient) else $error("divider result inconsistent");
endmodule : ctp_divider
`default_nettype wire

// ### tb/ctp_frame_sink.sv
// Frame receiver model standing in for the other nodes on the vehicle bus
`timescale 1ns/1ps
`default_nettype none
module ctp_frame_sink (
	input wire logic clk_i,
	input wire logic stall_i,
	input wire logic slow_i,
	input wire logic frame_valid_i,
	output logic frame_ready_o,
	input wire logic [15:0] frame_pgn_i,
	input wire logic [63:0] frame_data_i
);
	logic [79:0] got_q[$];
	logic [3:0] lfsr = 4'h1;
	logic rdy = 1'b1;
	// One process owns ready; the port only mirrors it
	assign frame_ready_o = rdy;
	// Take a frame on the handshake edge; a slow receiver drops ready on a pseudo-random pattern
	always @(posedge clk_i) begin
		if (frame_valid_i && frame_ready_o)
			got_q.push_back({frame_pgn_i, frame_data_i});
		lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
		rdy <= !stall_i && (!slow_i || lfsr[0]);
	end
endmodule : ctp_frame_sink
`default_nettype wire

// ### tb/ctp_packer_bench.sv
// Self-checking bench of the CAN transmit signal packer
`timescale 1ns/1ps
`default_nettype none
module ctp_packer_bench import ctp_pkg::*; ;
	logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic stall = 1'b0, slow = 1'b0, ce = 1'b1, awr, wrdy, bv, arr, rv, fv, frdy;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [127:0] ac = 128'h0;
	logic [15:0] fpgn;
	logic [63:0] fdata;
	logic [79:0] f;
	int err_count = 0, cmp_count = 0, n, sz[4], bytep[4], bitp[4];
	logic [31:0] rs[4], off[4];
	always #2.5 clk = ~clk;
	ctp_packer #(.MS_CYCLES(20)) dut (.REF_CLK_I(clk), .SRST_I(rst), .CE_I(ce),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp),
		.S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rready), .AC_VALUE_I(ac), .FRAME_VALID_O(fv), .FRAME_READY_I(frdy),
		.FRAME_PGN_O(fpgn), .FRAME_DATA_O(fdata));
	ctp_frame_sink sink (.clk_i(clk), .stall_i(stall), .slow_i(slow), .frame_valid_i(fv),
		.frame_ready_o(frdy), .frame_pgn_i(fpgn), .frame_data_i(fdata));
	// ==========================================================
	// Checking and closing
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic timeout(input string m);
		err_count++;
		$display("MISMATCH at %0t: no answer on %s", $time, m);
		report_and_stop();
	endtask : timeout
	// ==========================================================
	// Register bus master; handshakes are judged at the falling edge, where inputs are settled
	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		logic ha, hw, hb;
		@(posedge clk);
		awaddr <= a;
		wdata <= dt;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(negedge clk);
			ha = awv && awr;
			hw = wv && wrdy;
			hb = bv;
			@(posedge clk);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
			if (hb) begin
				bready <= 1'b0;
				return;
			end
		end
		timeout("write");
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rp);
		logic ha, hr;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(negedge clk);
			ha = arv && arr;
			hr = rv;
			dt = rdata;
			rp = rresp;
			@(posedge clk);
			if (ha) arv <= 1'b0;
			if (hr) begin
				rready <= 1'b0;
				return;
			end
		end
		timeout("read");
	endtask : rd
	// ==========================================================
	// Expected payload: scale each signal, place it low bit first, later signals overwrite
	function automatic logic [63:0] exp_frame(input logic [127:0] v);
		logic [63:0] e;
		logic signed [31:0] dlt;
		logic [31:0] mag, raw;
		int w, p;
		e = 64'h0;
		for (int s = 0; s < 4; s++) begin
			w = (sz[s] == 0) ? 0 : (sz[s] < 4) ? (1 << (sz[s] - 1)) : (8 << (sz[s] - 4));
			p = bytep[s] * 8 + ((sz[s] < 4) ? bitp[s] : 0);
			dlt = v[s*32 +: 32] - off[s];
			mag = (dlt < 0) ? -dlt : dlt;
			mag = mag / rs[s];
			raw = (dlt < 0) ? -mag : mag;
			for (int b = 0; b < w; b++) if (p + b < 64) e[p+b] = raw[b];
		end
		return e;
	endfunction : exp_frame
	task automatic cfg(input int s);
		wr(8'(32 + 16 * s), 32'(sz[s]) | 32'(bytep[s]) << 4 | 32'(bitp[s]) << 8 | 32'h12000 | 32'(s + 1) << 20);
		wr(8'(36 + 16 * s), rs[s]);
		wr(8'(40 + 16 * s), off[s]);
	endtask : cfg
	// Idle long enough for any frame still being built to leave, then forget it
	task automatic flush();
		repeat (400) @(posedge clk);
		sink.got_q.delete();
	endtask : flush
	task automatic one_frame(input logic [15:0] pgn);
		wr(8'h10, {16'd8, pgn});
		chk(64'(bresp), 64'(RESP_OKAY), "mapped write response");
		wr(8'h00, 32'h1);
		// A low clock enable holds the timers, so no frame may appear meanwhile
		ce <= 1'b0;
		repeat (600) @(posedge clk);
		chk(64'(sink.got_q.size()), 64'h0, "frame while clock enable low");
		ce <= 1'b1;
		for (int i = 0; i < 3000 && sink.got_q.size() == 0; i++) @(posedge clk);
		if (sink.got_q.size() == 0) timeout("frame");
		f = sink.got_q.pop_front();
		chk(64'(f[79:64]), 64'(pgn), "frame group number");
		chk(f[63:0], exp_frame(ac), "frame payload");
		wr(8'h00, 32'h0);
		flush();
	endtask : one_frame
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h1f5af0b9));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int s = 0; s < 4; s++) begin
			rd(8'(32 + 16 * s), d, r);
			chk(64'(d), 64'(32'h12005 | 32'(2 * s) << 4 | 32'(s + 1) << 20), "signal reset");
		end
		rd(8'h10, d, r);
		chk(64'(d), 64'h03e8ff00, "channel reset");
		rd(8'hfc, d, r);
		chk(64'(r), 64'(RESP_SLVERR), "unmapped read");
		rd(8'h04, d, r);
		chk(64'(d), 64'h0, "status reset");
		wr(8'hfc, 32'h0);
		chk(64'(bresp), 64'(RESP_SLVERR), "unmapped write");
		// Low two bytes only: the group number changes, the interval keeps its reset value
		wstrb <= 4'h3;
		wr(8'h10, 32'h1111_2222);
		wstrb <= 4'hf;
		rd(8'h10, d, r);
		chk(64'(d), 64'h03e8_2222, "byte strobes");
		$display("test reset values done");
		for (int s = 0; s < 4; s++) begin
			sz[s] = 5;
			bytep[s] = 2 * s;
			bitp[s] = 0;
			rs[s] = 32'h1;
			off[s] = 32'h0;
			ac[s*32 +: 32] <= $urandom;
		end
		one_frame(16'h1234);
		$display("test default layout done");
		// Signal one walks every size code; the others are drawn at random
		for (int it = 0; it < 7; it++) begin
			for (int s = 0; s < 4; s++) begin
				sz[s] = (s == 0) ? it : $urandom_range(6);
				bytep[s] = $urandom_range(7);
				bitp[s] = $urandom_range(7);
				rs[s] = 32'($urandom_range(9, 1));
				off[s] = 32'($urandom_range(200)) - 32'd100;
				ac[s*32 +: 32] <= 32'($urandom_range(60000)) - 32'd30000;
				cfg(s);
			end
			slow <= it[0];
			one_frame(16'(it + 16'h0100));
		end
		$display("test random layouts done");
		// Two channels on one group number: the lower one decides
		wr(8'h10, {16'd0, 16'h0abc});
		wr(8'h14, {16'd5, 16'h0abc});
		wr(8'h00, 32'h3);
		repeat (1000) @(posedge clk);
		chk(64'(sink.got_q.size()), 64'h0, "zero interval owner sent");
		wr(8'h10, {16'd20, 16'h0abc});
		repeat (2000) @(posedge clk);
		n = sink.got_q.size();
		cmp_count++;
		if (n < 4 || n > 6) begin
			err_count++;
			$display("MISMATCH at %0t: %0d frames with shared group number", $time, n);
		end
		wr(8'h00, 32'h0);
		flush();
		$display("test shared group number done");
		// Receiver stalls: two frames wait in the buffer, none is lost
		stall <= 1'b1;
		wr(8'h10, {16'd1, 16'h0055});
		wr(8'h00, 32'h1);
		repeat (1500) @(posedge clk);
		chk(64'(fv), 64'h1, "frame held while stalled");
		wr(8'h00, 32'h0);
		stall <= 1'b0;
		repeat (400) @(posedge clk);
		n = sink.got_q.size();
		chk(64'(n >= 2 && n <= 4), 64'h1, "frames after stall");
		while (sink.got_q.size() > 0) begin
			f = sink.got_q.pop_front();
			chk(f[63:0], exp_frame(ac), "buffered payload");
		end
		$display("test stalled receiver done");
		report_and_stop();
	end
endmodule : ctp_packer_bench
`default_nettype wire
